/* File: core/stc_cfg.svh */
/*
 * constants of the supervisor translation control register: field positions,
 * scheme encodings, reset value. assumes inclusion by both design files.
 */
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

`define STC_W32_MODE_POS     31
`define STC_W32_TAG_LSB      22
`define STC_W32_TAG_BITS     9
`define STC_W32_ROOT_BITS    22
`define STC_W64_MODE_LSB     60
`define STC_W64_MODE_BITS    4
`define STC_W64_TAG_LSB      44
`define STC_W64_TAG_BITS     16
`define STC_W64_ROOT_BITS    44
`define STC_PAGE_SHIFT       12
`define STC_MODE_NONE        4'h0
`define STC_MODE_PV32        4'h1
`define STC_MODE_PV39        4'h8
`define STC_MODE_PV48        4'h9
`define STC_MODE_PV57        4'hA
`define STC_MODE_PV64        4'hB
`define STC_W32_CUSTOM_HI    2'h3
`define STC_RESET_VALUE      64'h0

`endif

/* File: core/stc_pkg.sv */
/*
 * types of the supervisor translation control register.
 * assumes stc_cfg.svh is available on the include path.
 */
package stc_pkg;
    typedef enum logic [2:0] {
        STC_PRIV_USER  = 3'h1,
        STC_PRIV_SUPER = 3'h2,
        STC_PRIV_MACH  = 3'h4
    } stc_priv_t;
endpackage

/* File: core/stc_mode_check.sv */
/*
 * scheme support decoder: says whether a selector value is one the hart
 * implements, for the current supervisor word width.
 * assumes purely combinational use by the register block.
 */
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_mode_check
    import stc_pkg::*;
#(
    parameter bit HAS_PV32 = 1'b1,
    parameter bit HAS_PV39 = 1'b1,
    parameter bit HAS_PV48 = 1'b1,
    parameter bit HAS_PV57 = 1'b0
) (
    input  wire logic       wide_mode,
    input  wire logic [3:0] mode_in,
    output logic            supported,
    output logic            paged
);
    always_comb begin
        supported = 1'b0;
        paged     = 1'b0;
        if (!wide_mode) begin
            supported = (mode_in == `STC_MODE_NONE) ||
                        (mode_in == `STC_MODE_PV32 && HAS_PV32);
            paged     = (mode_in == `STC_MODE_PV32) && HAS_PV32;
        end else begin
            case (mode_in)
                `STC_MODE_NONE: supported = 1'b1;
                `STC_MODE_PV39: supported = HAS_PV39;
                `STC_MODE_PV48: supported = HAS_PV48;
                `STC_MODE_PV57: supported = HAS_PV57;
                // future 64-bit scheme, reserved and custom codes unsupported
                default:        supported = 1'b0;
            endcase
            paged = supported && (mode_in != `STC_MODE_NONE);
        end
    end
endmodule

/* File: core/stc_reg.sv */
/*
 * supervisor translation control register: holds scheme selector,
 * address-space tag and root page number, legalises writes, and presents
 * the active view to the translation walker and translation caches.
 * assumes a single-cycle control-register write port from the hart core,
 * the hart's clock and synchronous reset, and a decoded privilege mode.
 */
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_reg
    import stc_pkg::*;
#(
    parameter int TAG_WIDTH_32  = 9,
    parameter int TAG_WIDTH_64  = 16,
    parameter int ROOT_WIDTH_64 = 44,
    parameter bit HAS_PV32      = 1'b1,
    parameter bit HAS_PV39      = 1'b1,
    parameter bit HAS_PV48      = 1'b1,
    parameter bit HAS_PV57      = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wide_mode,
    input  wire logic        csr_write,
    input  wire logic [63:0] csr_wdata,
    output logic      [63:0] csr_rdata,
    input  wire stc_priv_t   priv_mode,
    output logic             reg_active,
    output logic             xlate_enable,
    output logic      [3:0]  scheme_select,
    output logic      [15:0] address_space_tag,
    output logic      [43:0] root_page_number,
    output logic      [55:0] root_table_addr,
    output logic             custom_encoding
);
    localparam int TAG32 = (TAG_WIDTH_32 > `STC_W32_TAG_BITS) ? `STC_W32_TAG_BITS
                                                               : TAG_WIDTH_32;
    localparam int TAG64 = (TAG_WIDTH_64 > `STC_W64_TAG_BITS) ? `STC_W64_TAG_BITS
                                                               : TAG_WIDTH_64;
    localparam int ROOT64 = (ROOT_WIDTH_64 > `STC_W64_ROOT_BITS) ? `STC_W64_ROOT_BITS
                                                                  : ROOT_WIDTH_64;

    typedef struct packed {
        logic [3:0]  mode;
        logic [15:0] tag;
        logic [43:0] root;
    } stc_state_t;

    stc_state_t state_reg;
    stc_state_t state_next;

    logic [3:0]  wr_mode;
    logic [15:0] wr_tag;
    logic [43:0] wr_root;
    logic [15:0] tag_mask;
    logic [43:0] root_mask;
    logic        wr_supported;
    logic        cur_paged;

    // decode incoming word per width
    always_comb begin
        if (wide_mode) begin
            wr_mode = csr_wdata[63:60];
            wr_tag  = csr_wdata[59:44];
            wr_root = csr_wdata[43:0];
            tag_mask  = 16'((32'h1 << TAG64) - 32'h1);
            root_mask = 44'((64'h1 << ROOT64) - 64'h1);
        end else begin
            wr_mode = {3'h0, csr_wdata[`STC_W32_MODE_POS]};
            wr_tag  = {7'h00, csr_wdata[30:22]};
            wr_root = {22'h0, csr_wdata[21:0]};
            tag_mask  = 16'((32'h1 << TAG32) - 32'h1);
            root_mask = 44'h00000_3FFFFF;
        end
    end

    stc_mode_check #(
        .HAS_PV32 (HAS_PV32),
        .HAS_PV39 (HAS_PV39),
        .HAS_PV48 (HAS_PV48),
        .HAS_PV57 (HAS_PV57)
    ) u_wr_check (
        .wide_mode (wide_mode),
        .mode_in   (wr_mode),
        .supported (wr_supported),
        .paged     ()
    );

    stc_mode_check #(
        .HAS_PV32 (HAS_PV32),
        .HAS_PV39 (HAS_PV39),
        .HAS_PV48 (HAS_PV48),
        .HAS_PV57 (HAS_PV57)
    ) u_cur_check (
        .wide_mode (wide_mode),
        .mode_in   (state_reg.mode),
        .supported (),
        .paged     (cur_paged)
    );

    // one write commits selector, tag and root together; the write has
    // no side effect on translation caches or page-table ordering
    always_comb begin
        state_next = state_reg;
        if (rst) begin
            state_next = stc_state_t'(`STC_RESET_VALUE);
        end else if (csr_write && wr_supported) begin
            state_next.mode = wr_mode;
            state_next.tag  = wr_tag & tag_mask;
            state_next.root = wr_root & root_mask;
            // nonzero fields kept as written under no translation; not used for walks, but narrow tag[8:7] drive custom_encoding
            if (wr_mode == `STC_MODE_NONE) begin
                state_next.tag  = wr_tag & tag_mask;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    // read view per width
    always_comb begin
        if (wide_mode) begin
            csr_rdata = {state_reg.mode, state_reg.tag, state_reg.root};
        end else begin
            csr_rdata = {32'h00000000, state_reg.mode[0], state_reg.tag[8:0],
                         state_reg.root[21:0]};
        end
    end

    assign reg_active = (priv_mode == STC_PRIV_SUPER) ||
                        (priv_mode == STC_PRIV_USER);
    // walker samples this at walk start only; a walk already running
    // is allowed to finish after the register goes inactive
    assign xlate_enable = reg_active && cur_paged;
    assign scheme_select     = state_reg.mode;
    assign address_space_tag = state_reg.tag;
    assign root_page_number  = state_reg.root;
    assign root_table_addr   = {state_reg.root, 12'h000};
    assign custom_encoding   = (state_reg.mode == `STC_MODE_NONE) && !wide_mode &&
                               (state_reg.tag[8:7] == `STC_W32_CUSTOM_HI);
endmodule

/* File: verification/stc_reg_props.sv */
/* port checker of the translation control register; bound into stc_reg,
   assumes its default parameters */
`timescale 1ns/1ps
module stc_reg_props
    import stc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        wide_mode,
    input wire logic        csr_write,
    input wire logic [63:0] csr_wdata,
    input wire logic [63:0] csr_rdata,
    input wire stc_priv_t   priv_mode,
    input wire logic        reg_active,
    input wire logic        xlate_enable,
    input wire logic [3:0]  scheme_select,
    input wire logic [15:0] address_space_tag,
    input wire logic [43:0] root_page_number,
    input wire logic [55:0] root_table_addr,
    input wire logic        custom_encoding
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0]  wm;
    logic [31:0] wlo;
    assign wm = csr_wdata[63:60];
    assign wlo = csr_wdata[31:0];
    AST_ACTIVE: assert property (reg_active == (priv_mode inside {STC_PRIV_SUPER, STC_PRIV_USER}))
        else $error("active flag");
    AST_DROP: assert property (csr_write && wide_mode && !(wm inside {0, 8, 9})
        |=> $stable(csr_rdata))
        else $error("bad scheme stored");
    AST_W64: assert property (csr_write && wide_mode && wm inside {0, 8, 9}
        |=> csr_rdata == $past(csr_wdata))
        else $error("wide layout");
    AST_VIEW: assert property (!wide_mode || csr_rdata ==
        {scheme_select, address_space_tag, root_page_number})
        else $error("field view");
    AST_W32: assert property (csr_write && !wide_mode |=> csr_rdata == {32'h0, $past(wlo)})
        else $error("narrow layout");
    AST_ROOT: assert property (root_table_addr == {root_page_number, 12'h000})
        else $error("root address");
    AST_XLATE: assert property (xlate_enable |-> reg_active &&
        (wide_mode ? csr_rdata[63:60] != 4'h0 : csr_rdata[31]))
        else $error("translation on");
    AST_BARE: assert property (csr_write && wide_mode && wm == 4'h0 |=> !xlate_enable)
        else $error("bare late");
    AST_CUSTOM: assert property (custom_encoding ==
        (!wide_mode && !csr_rdata[31] && csr_rdata[30:29] == 2'h3))
        else $error("custom flag");
    cover property (csr_write && wide_mode && wm == 4'h9);
    cover property (custom_encoding);
    cover property (xlate_enable && priv_mode == STC_PRIV_USER);
    cover property (csr_write && !wide_mode && wlo[31]);
endmodule
bind stc_reg stc_reg_props stc_reg_props_i (.sys_clk(sys_clk), .rst(rst), .wide_mode(wide_mode),
    .csr_write(csr_write), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .priv_mode(priv_mode),
    .reg_active(reg_active), .xlate_enable(xlate_enable), .scheme_select(scheme_select),
    .address_space_tag(address_space_tag), .root_page_number(root_page_number),
    .root_table_addr(root_table_addr), .custom_encoding(custom_encoding));

/* File: verification/stc_walker_model.sv */
/* walker model: takes root and tag when a walk starts;
   assumes the register outputs and a walk request from the bench */
`timescale 1ns/1ps
module stc_walker_model (
    input  wire logic        sys_clk,
    input  wire logic        walk_req,
    input  wire logic        xlate_enable,
    input  wire logic [55:0] root_table_addr,
    input  wire logic [15:0] address_space_tag,
    output logic      [71:0] walk_ctx
);
    // a started walk keeps its context even if the register changes later
    always_ff @(posedge sys_clk) begin
        if (walk_req && xlate_enable) begin
            walk_ctx <= {address_space_tag, root_table_addr};
        end
    end
endmodule

/* File: verification/tb.sv */
/* bench of the translation control register; assumes default parameters */
`timescale 1ns/1ps
module tb;
    import stc_pkg::*;
    logic        sys_clk = 0, rst = 1, wide_mode = 1, csr_write = 0, walk_req = 0;
    logic [63:0] csr_wdata = 64'h0, csr_rdata, v;
    stc_priv_t   priv_mode = STC_PRIV_SUPER;
    logic        reg_active, xlate_enable, custom_encoding;
    logic [3:0]  scheme_select;
    logic [15:0] address_space_tag;
    logic [43:0] root_page_number;
    logic [55:0] root_table_addr;
    logic [71:0] walk_ctx;
    int          n_mismatch = 0, n_compared = 0;
    always #50 sys_clk = ~sys_clk;
    stc_reg stc_reg_i (.sys_clk(sys_clk), .rst(rst), .wide_mode(wide_mode), .csr_write(csr_write),
        .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .priv_mode(priv_mode),
        .reg_active(reg_active), .xlate_enable(xlate_enable), .scheme_select(scheme_select),
        .address_space_tag(address_space_tag), .root_page_number(root_page_number),
        .root_table_addr(root_table_addr), .custom_encoding(custom_encoding));
    stc_walker_model stc_walker_model_i (.sys_clk(sys_clk), .walk_req(walk_req),
        .xlate_enable(xlate_enable), .root_table_addr(root_table_addr),
        .address_space_tag(address_space_tag), .walk_ctx(walk_ctx));
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [63:0] d);
        @(negedge sys_clk);
        csr_write = 1;
        csr_wdata = d;
        @(negedge sys_clk);
        csr_write = 0;
    endtask
    task automatic walk();
        walk_req = 1;
        @(negedge sys_clk);
        walk_req = 0;
    endtask
    task automatic t_wide();
        v = {4'h8, 16'hFFFF, 44'hABCDEF01234};
        wr(v);
        chk(csr_rdata, v);
        chk(root_table_addr, {v[43:0], 12'h000});
        chk({scheme_select, address_space_tag, root_page_number}, v);
        walk();
        chk(walk_ctx, {16'hFFFF, v[43:0], 12'h000});
        for (int m = 1; m < 16; m++) begin
            if (m != 8 && m != 9) begin
                wr({m[3:0], 60'h0});
                chk(csr_rdata, v);
            end
        end
        wr({4'h9, 60'h1});
        chk(xlate_enable, 1'b1);
        priv_mode = STC_PRIV_MACH;
        walk();
        chk({reg_active, walk_ctx}, {1'b0, 16'hFFFF, v[43:0], 12'h000});
        priv_mode = STC_PRIV_USER;
        wr(64'h0);
        chk(xlate_enable, 1'b0);
        $display("test wide done");
    endtask
    task automatic t_narrow();
        wide_mode = 0;
        v = {32'h0, 1'b1, 9'h1FF, 22'h2A5A5A};
        wr(v);
        chk(csr_rdata, v);
        chk(xlate_enable, 1'b1);
        wr({32'hFFFFFFFF, 3'h3, 29'h0});
        chk({custom_encoding, csr_rdata}, {1'b1, 32'h0, 3'h3, 29'h0});
        $display("test narrow done");
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        rst = 0;
        chk(csr_rdata, 64'h0);
        t_wide();
        t_narrow();
        conclude();
    end
endmodule
